/* File: logic/sas_defs.vh */
// register offsets, field positions and timing constants of the converter sequencer
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH
`define SAS_OFF_CTL        8'h00
`define SAS_OFF_TRG        8'h04
`define SAS_OFF_CFG        8'h08
`define SAS_OFF_INTF       8'h0c
`define SAS_OFF_DATA0      8'h20
`define SAS_CTL_MODULE_ENABLE      0
`define SAS_CTL_START      1
`define SAS_CTL_BUSY       10
`define SAS_CTL_IDX_LO     12
`define SAS_TRG_SMP_LO     0
`define SAS_TRG_SRC_LO     4
`define SAS_TRG_MODE       6
`define SAS_TRG_ALIGN      7
`define SAS_TRG_FIRST_LO   8
`define SAS_TRG_LAST_LO    11
`define SAS_TRG_RESET      16'h0007
`define SAS_SRC_SOFT       2'h0
`define SAS_SRC_TIMER      2'h1
`define SAS_SRC_EXT        2'h3
`define SAS_SMP_BASE       4'h4
`define SAS_CONV_CYCLES    4'hd
`endif

/* File: logic/sas_result_store.v */
// per-input result words with done and overrun flags
`timescale 1ns/100ps
`default_nettype none
module sas_result_store #(
  parameter NUM_INPUTS = 8
) (
  input  wire                    clk_sys,
  input  wire                    rst_n,
  input  wire                    load,
  input  wire [2:0]              loadIdx,
  input  wire [11:0]             loadData,
  input  wire [NUM_INPUTS-1:0]   clrDone,
  input  wire [NUM_INPUTS-1:0]   clrOver,
  input  wire [2:0]              rdIdx,
  output reg  [11:0]             rdData,
  output reg  [NUM_INPUTS-1:0]   doneFlag,
  output reg  [NUM_INPUTS-1:0]   overFlag
);
  reg [11:0] results [0:NUM_INPUTS-1];
  integer i;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      doneFlag <= {NUM_INPUTS{1'b0}};
      overFlag <= {NUM_INPUTS{1'b0}};
      rdData   <= 12'h000;
      for (i = 0; i < NUM_INPUTS; i = i + 1)
        results[i] <= 12'h000;
    end else begin
      rdData <= results[rdIdx];
      for (i = 0; i < NUM_INPUTS; i = i + 1) begin
        // set wins over a clear in the same cycle
        if (load && loadIdx == i[2:0]) begin
          results[i]  <= loadData;
          doneFlag[i] <= 1'b1;
          if (doneFlag[i] && !clrDone[i])
            overFlag[i] <= 1'b1;
          else if (clrOver[i])
            overFlag[i] <= 1'b0;
        end else begin
          if (clrDone[i])
            doneFlag[i] <= 1'b0;
          if (clrOver[i])
            overFlag[i] <= 1'b0;
        end
      end
    end
  end
endmodule // sas_result_store
`default_nettype wire

/* File: logic/sas_sequencer.v */
// converter sequencer top: AXI4-Lite registers, trigger gating, scan and timing
`timescale 1ns/100ps
`default_nettype none
`include "sas_defs.vh"
module sas_sequencer #(
  parameter NUM_INPUTS = 8
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_trigger_pin,
  input  wire        timer_underflow,
  output reg         sample_hold,
  output reg         convert_active,
  output reg  [2:0]  analog_select,
  input  wire [11:0] sar_result
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SAMP = 2'h1;
  localparam ST_CONV = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg        moduleEnable;
  reg        convStart;
  reg [15:0] trgReg;
  reg [1:0]  voltageRange;
  reg [1:0]  state;
  reg [3:0]  cycleCnt;
  reg [2:0]  curIdx;
  reg        busyFlag;
  reg        extPrev;
  reg        startPrev;
  reg        stopReq;

  wire [2:0] sampleTimeSel   = trgReg[`SAS_TRG_SMP_LO +: 3];
  wire [1:0] triggerSelect   = trgReg[`SAS_TRG_SRC_LO +: 2];
  wire       convModeSelect  = trgReg[`SAS_TRG_MODE];
  wire       resultAlignSel  = trgReg[`SAS_TRG_ALIGN];
  wire [2:0] firstInputSel   = trgReg[`SAS_TRG_FIRST_LO +: 3];
  wire [2:0] lastInputSel    = trgReg[`SAS_TRG_LAST_LO +: 3];

  function [15:0] align;
    input [11:0] raw;
    input        left;
    begin
      align = left ? {raw, 4'h0} : {4'h0, raw};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // trigger gating
  wire extFall  = extPrev & ~ext_trigger_pin;
  wire startSet = convStart & ~startPrev;
  reg  trigHit;
  always @* begin
    case (triggerSelect)
      `SAS_SRC_SOFT:  trigHit = startSet;
      `SAS_SRC_TIMER: trigHit = convStart & timer_underflow;
      `SAS_SRC_EXT:   trigHit = convStart & extFall;
      default:        trigHit = 1'b0;
    endcase
  end
  // analog side refuses to run with voltage range off
  wire trigAccept = trigHit & ~busyFlag & moduleEnable & (voltageRange != 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  reg        awHeld;
  reg        wHeld;
  reg [7:0]  awAddr;
  reg [31:0] wData;
  reg [3:0]  wStrb;
  // write-one-to-clear mask taken from one byte lane of the flag register
  function [NUM_INPUTS-1:0] laneClear;
    input       hit;
    input       strobe;
    input [7:0] lane;
    begin
      laneClear = (hit && strobe) ? lane[NUM_INPUTS-1:0] : {NUM_INPUTS{1'b0}};
    end
  endfunction

  // a write lands once both halves are held and no response is pending
  wire       doWrite   = awHeld & wHeld & ~s_axi_bvalid;
  wire       intfWrite = doWrite && awAddr == `SAS_OFF_INTF;
  wire [NUM_INPUTS-1:0] clrDone = laneClear(intfWrite, wStrb[0], wData[7:0]);
  wire [NUM_INPUTS-1:0] clrOver = laneClear(intfWrite, wStrb[1], wData[15:8]);
  wire       writeStop = doWrite && awAddr == `SAS_OFF_CTL && wStrb[0] && !wData[`SAS_CTL_START];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h0;
      wStrb         <= 4'h0;
      moduleEnable  <= 1'b0;
      convStart     <= 1'b0;
      trgReg        <= `SAS_TRG_RESET;
      voltageRange  <= 2'h0;
    end else begin
      s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (awAddr)
          `SAS_OFF_CTL: if (wStrb[0]) begin
            moduleEnable <= wData[`SAS_CTL_MODULE_ENABLE];
            convStart    <= wData[`SAS_CTL_START];
          end
          `SAS_OFF_TRG: begin
            // trigger setup changes only while idle
            if (!busyFlag && wStrb[0])
              trgReg[7:0] <= {wData[7:4], 1'b0, wData[2:0]};
            if (!busyFlag && wStrb[1])
              trgReg[15:8] <= {2'h0, wData[13:8]};
          end
          `SAS_OFF_CFG: if (wStrb[0] && !busyFlag)
            voltageRange <= wData[1:0];
          `SAS_OFF_INTF: begin
          end
          default: s_axi_bresp <= 2'h2;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan engine
  wire [3:0] sampleCycles = `SAS_SMP_BASE + {1'b0, sampleTimeSel};
  wire       lastOfScan   = (curIdx == lastInputSel);
  wire       convEnd      = (state == ST_CONV) && (cycleCnt == `SAS_CONV_CYCLES - 4'h1);
  wire       resultLoad   = convEnd;

  // scan order: ascending, back to the first input after the last
  function [2:0] nextInput;
    input [2:0] cur;
    input [2:0] first;
    input       atLast;
    begin
      nextInput = atLast ? first : cur + 3'h1;
    end
  endfunction

  // one clock for the whole engine, so no crossing to guard
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state          <= ST_IDLE;
      cycleCnt       <= 4'h0;
      curIdx         <= 3'h0;
      busyFlag       <= 1'b0;
      extPrev        <= 1'b1;
      startPrev      <= 1'b0;
      stopReq        <= 1'b0;
      sample_hold    <= 1'b0;
      convert_active <= 1'b0;
      analog_select  <= 3'h0;
    end else begin
      extPrev   <= ext_trigger_pin;
      startPrev <= convStart;
      if (writeStop && busyFlag)
        stopReq <= 1'b1;
      case (state)
        ST_IDLE: begin
          stopReq <= 1'b0;
          if (trigAccept) begin
            state       <= ST_SAMP;
            cycleCnt    <= 4'h0;
            curIdx      <= firstInputSel;
            busyFlag    <= 1'b1;
            sample_hold <= 1'b1;
            analog_select <= firstInputSel;
          end
        end
        ST_SAMP: begin
          if (cycleCnt == sampleCycles - 4'h1) begin
            state          <= ST_CONV;
            cycleCnt       <= 4'h0;
            sample_hold    <= 1'b0;
            convert_active <= 1'b1;
          end else
            cycleCnt <= cycleCnt + 4'h1;
        end
        ST_CONV: begin
          if (convEnd) begin
            convert_active <= 1'b0;
            cycleCnt       <= 4'h0;
            if (stopReq || writeStop || !convStart) begin
              state    <= ST_IDLE;
              busyFlag <= 1'b0;
            end else if (lastOfScan && !convModeSelect) begin
              state    <= ST_IDLE;
              busyFlag <= 1'b0;
            end else begin
              state       <= ST_SAMP;
              sample_hold <= 1'b1;
              curIdx        <= nextInput(curIdx, firstInputSel, lastOfScan);
              analog_select <= nextInput(curIdx, firstInputSel, lastOfScan);
            end
          end else
            cycleCnt <= cycleCnt + 4'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results and flags
  wire [NUM_INPUTS-1:0] doneFlag;
  wire [NUM_INPUTS-1:0] overrunFlag;
  wire [11:0]           rdResult;
  wire [2:0]            rdSel = s_axi_araddr[4:2];

  sas_result_store #(
    .NUM_INPUTS (NUM_INPUTS)
  ) u_store (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (resultLoad),
    .loadIdx  (curIdx),
    .loadData (sar_result),
    .clrDone  (clrDone),
    .clrOver  (clrOver),
    .rdIdx    (rdSel),
    .rdData   (rdResult),
    .doneFlag (doneFlag),
    .overFlag (overrunFlag)
  );

  // shown index: current while busy, last converted after, wrapped past top
  localparam [31:0] TOP_INPUT = NUM_INPUTS - 1;
  wire [2:0] shownIdx = (!busyFlag && curIdx == TOP_INPUT[2:0]) ? 3'h0 : curIdx;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: address taken, data one cycle later from the store
  reg       rdPend;
  reg [7:0] arAddr;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
      rdPend        <= 1'b0;
      arAddr        <= 8'h00;
    end else begin
      s_axi_arready <= ~rdPend & ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rdPend <= 1'b1;
        arAddr <= s_axi_araddr;
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rdPend) begin
        rdPend       <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (arAddr[7:5])
          3'h0: case (arAddr[4:2])
            3'h0: s_axi_rdata <= {16'h0, 1'b0, shownIdx, 1'b0, busyFlag, 8'h00, convStart, moduleEnable};
            3'h1: s_axi_rdata <= {16'h0, trgReg};
            3'h2: s_axi_rdata <= {30'h0, voltageRange};
            3'h3: s_axi_rdata <= {16'h0, overrunFlag, doneFlag};
            default: begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'h2;
            end
          endcase
          default: begin
            // result window only; the rest of the upper map answers with an error
            if (arAddr[7:5] == 3'h1) begin
              s_axi_rdata <= {16'h0, align(rdResult, resultAlignSel)};
            end else begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'h2;
            end
          end
        endcase
      end
    end
  end
endmodule // sas_sequencer
`default_nettype wire

/* File: testbench/sas_seq_properties.sv */
// port timing checks of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sas_seq_properties (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        sample_hold,
  input wire        convert_active,
  input wire [2:0]  analog_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // run lengths of the two phases, zeroed when the phase is low
  logic [4:0] smpCnt;
  logic [4:0] cnvCnt;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      smpCnt <= 5'h00;
      cnvCnt <= 5'h00;
    end else begin
      smpCnt <= sample_hold ? smpCnt + 5'h01 : 5'h00;
      cnvCnt <= convert_active ? cnvCnt + 5'h01 : 5'h00;
    end
  end
  phase_excl_a: assert property (!(sample_hold && convert_active))
    else $error("sampling and conversion overlap");
  conv_len_a: assert property ($fell(convert_active) |-> cnvCnt == 5'h0d)
    else $error("conversion phase not 13 cycles");
  smp_len_a: assert property ($fell(sample_hold) |-> smpCnt >= 5'h04 && smpCnt <= 5'h0b)
    else $error("sampling phase out of range");
  conv_follow_a: assert property ($fell(sample_hold) |-> convert_active)
    else $error("sampling not followed by conversion");
  sel_stable_a: assert property (convert_active |-> $stable(analog_select))
    else $error("input changed during conversion");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read data late");
  ar_cause_a: assert property ($rose(s_axi_arready) |-> s_axi_arvalid)
    else $error("address ready without request");
endmodule // sas_seq_properties
`default_nettype wire

/* File: testbench/test_sar_adc_sequencer.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sas_defs.vh"
module test_sar_adc_sequencer;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  aw = 8'h00;
  logic [7:0]  ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0]  ws = 4'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        arv = 1'b0;
  logic        ext = 1'b1;
  logic        tmr = 1'b0;
  logic [11:0] sar = 12'h000;
  logic        awr, wr_, bv, arr, rv, sh, ca, shD;
  logic [1:0]  br, rr, wrResp;
  logic [31:0] rdt;
  logic [2:0]  sel;
  logic [2:0]  seq[$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          cur, smpLen;
  sas_sequencer dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .ext_trigger_pin(ext), .timer_underflow(tmr), .sample_hold(sh), .convert_active(ca),
    .analog_select(sel), .sar_result(sar));
  initial forever #20 clk_sys = ~clk_sys;
  // result marks which input it came from
  always @(posedge clk_sys) begin
    sar <= {9'h14a, sel};
    shD <= sh;
    if (sh && !shD) begin
      seq.push_back(sel);
      cur = 1;
    end else if (sh) cur++;
    if (!sh && shD) smpLen = cur;
  end
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    aw <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (!bv);
    wrResp = br;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ar <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdt;
    r = rr;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d & m);
  endtask
  task automatic idle();
    logic [31:0] d;
    logic [1:0]  r;
    do rd(`SAS_OFF_CTL, d, r); while (d[`SAS_CTL_BUSY] !== 1'b0);
  endtask
  task automatic start(input logic [15:0] t);
    seq.delete();
    wr(`SAS_OFF_CTL, 32'h1, 4'h1);
    wr(`SAS_OFF_TRG, {16'h0, t}, 4'h3);
    wr(`SAS_OFF_CFG, 32'h3, 4'h1);
    wr(`SAS_OFF_CTL, 32'h3, 4'h1);
  endtask
  task automatic pulse();
    tmr <= 1'b1;
    @(posedge clk_sys);
    tmr <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rc("ctl", `SAS_OFF_CTL, 32'hffff, 32'h0);
    rc("trg", `SAS_OFF_TRG, 32'hffff, 32'h7);
    rd(8'hfc, d, r);
    chk("resp", 32'h2, {30'h0, r});
    wr(8'hfc, 32'h3, 4'hf);
    chk("bresp", 32'h2, {30'h0, wrResp});
    // one-time scan of 2..4, shortest sampling, right aligned
    start(16'h2200);
    idle();
    chk("scan", 32'h234, {1'b0, seq[0], 1'b0, seq[1], 1'b0, seq[2]});
    chk("count", 32'h3, seq.size());
    chk("smp", 32'h4, smpLen);
    rc("idx", `SAS_OFF_CTL, 32'h7000, 32'h4000);
    rc("done", `SAS_OFF_INTF, 32'hffff, 32'h1c);
    rc("res2", `SAS_OFF_DATA0 + 8'h08, 32'hffff, 32'ha52);
    // start stays set and holding it gives no new scan
    wr(`SAS_OFF_CTL, 32'h3, 4'h1);
    repeat (30) @(posedge clk_sys);
    chk("hold", 32'h3, seq.size());
    rc("start", `SAS_OFF_CTL, 32'h2, 32'h2);
    // longest sampling, left aligned, input 2 again while its flag is set
    start(16'h1287);
    idle();
    chk("smp", 32'hb, smpLen);
    chk("first", 32'h2, seq[0]);
    rc("res2", `SAS_OFF_DATA0 + 8'h08, 32'hffff, 32'ha520);
    rc("res3", `SAS_OFF_DATA0 + 8'h0c, 32'hffff, 32'ha530);
    rc("over", `SAS_OFF_INTF, 32'hffff, 32'h41c);
    wr(`SAS_OFF_INTF, 32'hffff, 4'h3);
    chk("wresp", 32'h0, {30'h0, wrResp});
    rc("clr", `SAS_OFF_INTF, 32'hffff, 32'h0);
    // continuous 3..4, stopped during the second round
    start(16'h2340);
    do @(posedge clk_sys); while (seq.size() < 3);
    wr(`SAS_OFF_CTL, 32'h1, 4'h1);
    idle();
    chk("cont", 32'h343, {1'b0, seq[0], 1'b0, seq[1], 1'b0, seq[2]});
    chk("stop", 32'h3, seq.size());
    rc("idx", `SAS_OFF_CTL, 32'h7000, 32'h3000);
    // timer trigger on the top input, whose shown index wraps after the scan
    start(16'h3f10);
    repeat (5) @(posedge clk_sys);
    chk("armed", 32'h0, seq.size());
    pulse();
    repeat (3) @(posedge clk_sys);
    rc("busy", `SAS_OFF_CTL, 32'h7400, 32'h7400);
    pulse();
    idle();
    chk("ignored", 32'h1, seq.size());
    pulse();
    idle();
    chk("again", 32'h2, seq.size());
    rc("wrap", `SAS_OFF_CTL, 32'h7000, 32'h0);
    // external trigger: an edge before arming does nothing
    seq.delete();
    wr(`SAS_OFF_CTL, 32'h1, 4'h1);
    wr(`SAS_OFF_TRG, 32'h30, 4'h3);
    ext <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ext <= 1'b1;
    wr(`SAS_OFF_CTL, 32'h3, 4'h1);
    repeat (5) @(posedge clk_sys);
    chk("unarmed", 32'h0, seq.size());
    ext <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ext <= 1'b1;
    idle();
    chk("ext", 32'h1, seq.size());
    summarize();
  end
endmodule // test_sar_adc_sequencer
bind sas_sequencer sas_seq_properties chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .sample_hold(sample_hold), .convert_active(convert_active),
  .analog_select(analog_select));
`default_nettype wire
